// ==== idt_pkg.sv ====
// Shared constants and types for the instruction decode and timing block
package idt_pkg;
  localparam int INSTR_W = 14;
  localparam int PC_W = 15;
  localparam int DATA_W = 8;
  localparam int FA_W = 7;
  localparam int Q_PER_CYCLE = 4;
  localparam int OSC_PERIOD_NS = 10;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [1:0] STALL_RESET = 2'h1;
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  // File address range and indirect register locations
  localparam logic [FA_W-1:0] FA_MIN = 7'h00;
  localparam logic [FA_W-1:0] FA_MAX = 7'h7F;
  localparam logic [FA_W-1:0] IND0_ADDR = 7'h00;
  localparam logic [FA_W-1:0] IND1_ADDR = 7'h01;
  // Group select in word bits 13:12
  localparam logic [1:0] GRP_BYTE_CODE = 2'h0;
  localparam logic [1:0] GRP_BIT_CODE = 2'h1;
  // Byte operation codes in bits 11:8
  localparam logic [3:0] BOP_MOVE_TO = 4'h0;
  localparam logic [3:0] BOP_CLEAR = 4'h1;
  localparam logic [3:0] BOP_SUB = 4'h2;
  localparam logic [3:0] BOP_DEC = 4'h3;
  localparam logic [3:0] BOP_IOR = 4'h4;
  localparam logic [3:0] BOP_AND = 4'h5;
  localparam logic [3:0] BOP_XOR = 4'h6;
  localparam logic [3:0] BOP_ADD = 4'h7;
  localparam logic [3:0] BOP_MOVE = 4'h8;
  localparam logic [3:0] BOP_COMP = 4'h9;
  localparam logic [3:0] BOP_INC = 4'hA;
  localparam logic [3:0] BOP_DEC_SKIP = 4'hB;
  localparam logic [3:0] BOP_ROT_R = 4'hC;
  localparam logic [3:0] BOP_ROT_L = 4'hD;
  localparam logic [3:0] BOP_SWAP = 4'hE;
  localparam logic [3:0] BOP_INC_SKIP = 4'hF;
  // Bit operation codes in bits 11:10
  localparam logic [1:0] BIT_CLR = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  localparam logic [1:0] BIT_SKIP_CLR = 2'h2;
  localparam logic [1:0] BIT_SKIP_SET = 2'h3;
  // Literal and control encodings
  localparam logic [2:0] OP_CALL = 3'h4;
  localparam logic [2:0] OP_JUMP = 3'h5;
  localparam logic [5:0] OP_MOVE_LIT = 6'h30;
  localparam logic [4:0] OP_REL_BRANCH = 5'h19;
  localparam logic [3:0] OP_RET_LIT = 4'hD;
  localparam logic [5:0] OP_IOR_LIT = 6'h38;
  localparam logic [5:0] OP_AND_LIT = 6'h39;
  localparam logic [5:0] OP_XOR_LIT = 6'h3A;
  localparam logic [4:0] OP_SUB_LIT = 5'h1E;
  localparam logic [4:0] OP_ADD_LIT = 5'h1F;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RET_INT = 14'h0009;
  localparam logic [13:0] OP_CALL_ACC = 14'h000A;
  localparam logic [13:0] OP_BRANCH_ACC = 14'h000B;
  localparam logic [9:0] OP_IND_MOVE = 10'h001;
  // Pointer update modes
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;
  typedef enum {IDT_GRP_BYTE, IDT_GRP_BIT, IDT_GRP_LIT} idt_group_t;
endpackage

// ==== idt_fields_if.sv ====
// Decoded fields and phase shared between core modules
`timescale 1ns/1ps
interface idt_fields_if;
  import idt_pkg::*;
  logic [1:0] q;
  logic [INSTR_W-1:0] word;
  idt_group_t group;
  logic is_ctrl;
  logic [3:0] byte_op;
  logic dest;
  logic [FA_W-1:0] fa;
  logic [1:0] bit_op;
  logic [2:0] bit_sel;
  logic [10:0] lit;
  logic ptr_num;
  logic [1:0] pointer_update_mode;
  modport phase (output q);
  modport dec (input word, output group, is_ctrl, byte_op, dest, fa, bit_op,
    bit_sel, lit, ptr_num, pointer_update_mode);
  modport core (input q, group, is_ctrl, byte_op, dest, fa, bit_op, bit_sel,
    lit, ptr_num, pointer_update_mode, output word);
endinterface

// ==== idt_phase_gen.sv ====
// Oscillator phase counter, four per instruction cycle
`timescale 1ns/1ps
module idt_phase_gen
  import idt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Phase out
  idt_fields_if.phase fif
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fif.q <= Q1;
    end else begin
      fif.q <= fif.q + 2'h1;
    end
  end
endmodule // idt_phase_gen

// ==== idt_field_dec.sv ====
// Splits an instruction word into its fields
`timescale 1ns/1ps
module idt_field_dec
  import idt_pkg::*;
(
  // Fields
  idt_fields_if.dec fif
);
  always_comb begin
    fif.is_ctrl = (fif.word[13:12] == GRP_BYTE_CODE)
      && (fif.word[11:7] == 5'h00);
    if (fif.is_ctrl) begin
      fif.group = IDT_GRP_LIT;
    end else if (fif.word[13:12] == GRP_BYTE_CODE) begin
      fif.group = IDT_GRP_BYTE;
    end else if (fif.word[13:12] == GRP_BIT_CODE) begin
      fif.group = IDT_GRP_BIT;
    end else begin
      fif.group = IDT_GRP_LIT;
    end
  end
  assign fif.byte_op = fif.word[11:8];
  assign fif.dest = fif.word[7];
  assign fif.fa = fif.word[6:0];
  assign fif.bit_op = fif.word[11:10];
  assign fif.bit_sel = fif.word[9:7];
  assign fif.lit = fif.word[10:0];
  assign fif.ptr_num = fif.word[2];
  assign fif.pointer_update_mode = fif.word[1:0];
endmodule // idt_field_dec

// ==== idt_decode_timing.sv ====
// Instruction decode, cycle timing and read-modify-write sequencing
// Functional notes
// - One fourteen-bit word holds opcode and operands
// - Classify into byte, bit, literal-control groups
// - Other instructions finish in one cycle
// - Calls, direct or by accumulator, take two
// - All three return kinds take two cycles
// - Jumps, branches and skips take two cycles
// - Indirect access to program memory adds one
// - Four oscillator clocks make one instruction cycle
// - File operand always read before result stored
// - Destination bit zero accumulator, one file register
// - File address field spans 0x00 to 0x7F
// - Bit field picks one of eight bits
// - Don't-care instruction bits never affect execution
// - Pointer number selects pointer pair 0 or 1
// - Mode picks pre/post increment or decrement
// - Literal field feeds datapath or program counter
`timescale 1ns/1ps
module idt_decode_timing
  import idt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Program memory
  input wire logic [INSTR_W-1:0] pm_word,
  output logic [PC_W-1:0] pm_addr,
  output logic pm_fetch,
  // Data register file
  input wire logic [DATA_W-1:0] rf_rdata,
  output logic [FA_W-1:0] rf_addr,
  output logic rf_rd,
  output logic rf_wr,
  output logic [DATA_W-1:0] rf_wdata,
  // Accumulator
  input wire logic [DATA_W-1:0] acc_in,
  output logic acc_wr,
  output logic [DATA_W-1:0] acc_wdata,
  // File select pointers
  input wire logic [1:0] ptr_in_prog,
  output logic ptr_upd,
  output logic ptr_sel,
  output logic [1:0] pointer_update_mode,
  // Return stack
  input wire logic [PC_W-1:0] ret_addr,
  output logic stack_push,
  output logic stack_pop,
  output logic [PC_W-1:0] push_addr,
  // Timing status
  output logic cycle_start,
  output logic nop_slot
);
  logic rs1;
  logic rst_n;
  logic [INSTR_W-1:0] ir;
  logic [1:0] stall_cnt;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] bit_mask;
  logic [1:0] extra;
  logic act;
  logic is_file;
  logic ind_move;
  logic ind_write;
  logic f_is_ind;
  logic ind_ptr;
  logic ind_prog;
  logic op_call;
  logic op_jump;
  logic op_ret;
  logic op_ret_int;
  logic op_ret_lit;
  logic op_call_acc;
  logic op_br_acc;
  logic op_rel_br;
  logic op_move_lit;
  logic op_lit_alu;
  logic op_bit_skip;
  logic op_cnt_skip;
  logic two_cycle;
  logic skip;
  logic wr_file;
  logic wr_acc;
  logic pre_mode;

  idt_fields_if fif ();

  // Reset release through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rs1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1 <= 1'b1;
      rst_n <= rs1;
    end
  end

  idt_phase_gen u_phase (
    .mclk(mclk),
    .rst_n(rst_n),
    .fif(fif)
  );

  idt_field_dec u_dec (
    .fif(fif)
  );

  assign fif.word = ir;

  // Instruction classification
  always_comb begin
    act = !nop_slot;
    is_file = act && (fif.group != IDT_GRP_LIT);
    ind_move = act && (ir[13:4] == OP_IND_MOVE);
    ind_write = ind_move && ir[3];
    pre_mode = !fif.pointer_update_mode[1];
    f_is_ind = is_file && (fif.fa == IND0_ADDR || fif.fa == IND1_ADDR);
    ind_ptr = ind_move ? fif.ptr_num : fif.fa[0];
    ind_prog = (f_is_ind || ind_move) && ptr_in_prog[ind_ptr];
    op_call = act && (ir[13:11] == OP_CALL);
    op_jump = act && (ir[13:11] == OP_JUMP);
    op_ret = act && (ir == OP_RETURN);
    op_ret_int = act && (ir == OP_RET_INT);
    op_call_acc = act && (ir == OP_CALL_ACC);
    op_br_acc = act && (ir == OP_BRANCH_ACC);
    // Bits 9:8 of the return-literal form are ignored
    op_ret_lit = act && (ir[13:10] == OP_RET_LIT);
    op_rel_br = act && (ir[13:9] == OP_REL_BRANCH);
    op_move_lit = act && (ir[13:8] == OP_MOVE_LIT);
    op_lit_alu = act && (ir[13:8] == OP_IOR_LIT || ir[13:8] == OP_AND_LIT
      || ir[13:8] == OP_XOR_LIT || ir[13:9] == OP_SUB_LIT
      || ir[13:9] == OP_ADD_LIT);
    op_bit_skip = is_file && (fif.group == IDT_GRP_BIT) && fif.bit_op[1];
    op_cnt_skip = is_file && (fif.group == IDT_GRP_BYTE)
      && (fif.byte_op == BOP_DEC_SKIP || fif.byte_op == BOP_INC_SKIP);
    two_cycle = op_call || op_call_acc
      || op_ret || op_ret_lit || op_ret_int
      || op_jump || op_rel_br || op_br_acc || op_bit_skip
      || op_cnt_skip;
    extra = {1'b0, two_cycle} + {1'b0, ind_prog};
  end

  // Modify stage
  always_comb begin
    bit_mask = 8'h01 << fif.bit_sel;
    result = rf_rdata;
    if (ind_write) begin
      result = acc_in;
    end else if (fif.group == IDT_GRP_BIT) begin
      result = (fif.bit_op == BIT_SET) ? (rf_rdata | bit_mask)
        : (rf_rdata & ~bit_mask);
    end else if (fif.group == IDT_GRP_BYTE) begin
      case (fif.byte_op)
        BOP_MOVE_TO: result = acc_in;
        BOP_CLEAR: result = 8'h00;
        BOP_SUB: result = rf_rdata - acc_in;
        BOP_DEC: result = rf_rdata - 8'h01;
        BOP_IOR: result = rf_rdata | acc_in;
        BOP_AND: result = rf_rdata & acc_in;
        BOP_XOR: result = rf_rdata ^ acc_in;
        BOP_ADD: result = rf_rdata + acc_in;
        BOP_MOVE: result = rf_rdata;
        BOP_COMP: result = ~rf_rdata;
        BOP_INC: result = rf_rdata + 8'h01;
        BOP_DEC_SKIP: result = rf_rdata - 8'h01;
        BOP_ROT_R: result = {rf_rdata[0], rf_rdata[7:1]};
        BOP_ROT_L: result = {rf_rdata[6:0], rf_rdata[7]};
        BOP_SWAP: result = {rf_rdata[3:0], rf_rdata[7:4]};
        BOP_INC_SKIP: result = rf_rdata + 8'h01;
        default: result = rf_rdata;
      endcase
    end else if (op_move_lit || op_ret_lit) begin
      result = fif.lit[7:0];
    end else if (ir[13:8] == OP_IOR_LIT) begin
      result = acc_in | fif.lit[7:0];
    end else if (ir[13:8] == OP_AND_LIT) begin
      result = acc_in & fif.lit[7:0];
    end else if (ir[13:8] == OP_XOR_LIT) begin
      result = acc_in ^ fif.lit[7:0];
    end else if (ir[13:9] == OP_SUB_LIT) begin
      result = fif.lit[7:0] - acc_in;
    end else if (ir[13:9] == OP_ADD_LIT) begin
      result = fif.lit[7:0] + acc_in;
    end
  end

  // Result steering and skip decision
  always_comb begin
    wr_file = 1'b0;
    wr_acc = 1'b0;
    if (ind_move) begin
      wr_file = ind_write;
      wr_acc = !ind_write;
    end else if (is_file && fif.group == IDT_GRP_BIT) begin
      wr_file = !fif.bit_op[1];
    end else if (is_file) begin
      wr_file = fif.dest;
      wr_acc = !fif.dest;
    end else if (op_move_lit || op_lit_alu || op_ret_lit) begin
      wr_acc = 1'b1;
    end
    skip = 1'b0;
    if (op_bit_skip) begin
      skip = (fif.bit_op == BIT_SKIP_SET) ? ((rf_rdata & bit_mask) != 8'h00)
        : ((rf_rdata & bit_mask) == 8'h00);
    end else if (op_cnt_skip) begin
      skip = (result == 8'h00);
    end
  end

  // Program counter target
  always_comb begin
    next_pc = pc;
    if (op_call || op_jump) begin
      next_pc = {pc[PC_W-1:11], fif.lit};
    end else if (op_call_acc) begin
      next_pc = {pc[PC_W-1:8], acc_in};
    end else if (op_ret || op_ret_int || op_ret_lit) begin
      next_pc = ret_addr;
    end else if (op_rel_br) begin
      next_pc = pc + {{(PC_W-9){fif.lit[8]}}, fif.lit[8:0]};
    end else if (op_br_acc) begin
      next_pc = pc + {{(PC_W-DATA_W){1'b0}}, acc_in};
    end else if (skip) begin
      next_pc = pc + 15'h0001;
    end
  end

  // Issue, stall slots and fetch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ir <= 14'h0000;
      nop_slot <= 1'b1;
      stall_cnt <= STALL_RESET;
      pc <= PC_RESET;
      pm_addr <= PC_RESET;
      pm_fetch <= 1'b0;
      cycle_start <= 1'b0;
    end else begin
      pm_fetch <= 1'b0;
      cycle_start <= (fif.q == Q4);
      if (fif.q == Q1) begin
        if (stall_cnt != 2'h0) begin
          nop_slot <= 1'b1;
          stall_cnt <= stall_cnt - 2'h1;
        end else begin
          nop_slot <= 1'b0;
          ir <= pm_word;
          pc <= pc + 15'h0001;
        end
      end else if (fif.q == Q4) begin
        if (nop_slot) begin
          if (stall_cnt == 2'h0) begin
            pm_addr <= pc;
            pm_fetch <= 1'b1;
          end
        end else begin
          pc <= next_pc;
          stall_cnt <= extra;
          if (extra == 2'h0) begin
            pm_addr <= next_pc;
            pm_fetch <= 1'b1;
          end
        end
      end
    end
  end

  // File register read then write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rf_addr <= 7'h00;
      rf_rd <= 1'b0;
      rf_wr <= 1'b0;
      rf_wdata <= 8'h00;
      acc_wr <= 1'b0;
      acc_wdata <= 8'h00;
    end else begin
      rf_rd <= 1'b0;
      rf_wr <= 1'b0;
      acc_wr <= 1'b0;
      if (fif.q == Q3 && (is_file || ind_move)) begin
        rf_addr <= ind_move ? (fif.ptr_num ? IND1_ADDR : IND0_ADDR)
          : fif.fa;
        rf_rd <= 1'b1;
      end
      if (fif.q == Q4) begin
        rf_wr <= wr_file;
        acc_wr <= wr_acc;
        if (wr_file) begin
          rf_wdata <= result;
        end
        if (wr_acc) begin
          acc_wdata <= result;
        end
      end
    end
  end

  // Pointer updates and stack
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_upd <= 1'b0;
      ptr_sel <= 1'b0;
      pointer_update_mode <= MODE_PRE_INC;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      push_addr <= PC_RESET;
    end else begin
      ptr_upd <= 1'b0;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      if (ind_move && ((fif.q == Q2 && pre_mode)
          || (fif.q == Q4 && !pre_mode))) begin
        ptr_upd <= 1'b1;
        ptr_sel <= fif.ptr_num;
        pointer_update_mode <= fif.pointer_update_mode;
      end
      if (fif.q == Q4) begin
        stack_push <= op_call || op_call_acc;
        stack_pop <= op_ret || op_ret_int || op_ret_lit;
        push_addr <= pc;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_fetch_phase: assert property (pm_fetch |-> fif.q == Q1)
    else $error("fetch outside first phase");
  chk_cycle_period: assert property (
    cycle_start |=> !cycle_start [*3] ##1 cycle_start)
    else $error("instruction cycle not four clocks");
  chk_read_first: assert property (rf_wr |-> $past(rf_rd))
    else $error("file write without prior read");
  chk_dest_file: assert property (
    (fif.q == Q4 && is_file && fif.group == IDT_GRP_BYTE && fif.dest)
    |=> rf_wr && !acc_wr)
    else $error("destination one not steered to file");
  chk_single_cycle: assert property (
    (fif.q == Q4 && act && extra == 2'h0) |=> pm_fetch)
    else $error("single cycle instruction stalled");
  chk_two_cycle: assert property (
    (fif.q == Q4 && act && extra == 2'h1) |=> !pm_fetch ##4 pm_fetch)
    else $error("two cycle timing wrong");
  chk_three_cycle: assert property (
    (fif.q == Q4 && act && extra == 2'h2) |=> !pm_fetch ##8 pm_fetch)
    else $error("indirect extra cycle missing");
  chk_addr_field: assert property (
    (fif.q == Q3 && is_file) |=> rf_rd && rf_addr == $past(ir[6:0]))
    else $error("file address not from field");
  chk_bit_clear: assert property (
    (fif.q == Q4 && is_file && fif.group == IDT_GRP_BIT
    && fif.bit_op == BIT_CLR) |=> rf_wr && !rf_wdata[$past(ir[9:7])])
    else $error("bit clear missed target bit");
  chk_pre_update: assert property (
    (fif.q == Q2 && ind_move && pre_mode) |=> ptr_upd ##1 rf_rd)
    else $error("pre update not before read");
  chk_literal_acc: assert property (
    (fif.q == Q4 && op_move_lit) |=> acc_wr && acc_wdata == $past(ir[7:0]))
    else $error("literal not moved to accumulator");
  chk_nop_quiet: assert property (
    nop_slot |-> !rf_rd && !stack_push && !stack_pop)
    else $error("activity in no-operation slot");
endmodule // idt_decode_timing

// ==== idt_mem_model.sv ====
// Program memory, register file, accumulator and return stack model
`timescale 1ns/1ps
module idt_mem_model
  import idt_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Program memory
  input wire logic [PC_W-1:0] pm_addr,
  input wire logic pm_fetch,
  output logic [INSTR_W-1:0] pm_word,
  // Register file and accumulator
  input wire logic [FA_W-1:0] rf_addr,
  input wire logic rf_rd,
  input wire logic rf_wr,
  input wire logic [DATA_W-1:0] rf_wdata,
  output logic [DATA_W-1:0] rf_rdata,
  input wire logic acc_wr,
  input wire logic [DATA_W-1:0] acc_wdata,
  output logic [DATA_W-1:0] acc,
  // Return stack
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [PC_W-1:0] push_addr,
  output logic [PC_W-1:0] ret_addr
);
  logic [INSTR_W-1:0] prog [0:63];
  logic [DATA_W-1:0] regs [0:127];
  logic [PC_W-1:0] stk [0:15];
  logic [3:0] sp = 4'h0;
  logic [INSTR_W-1:0] last_w = 14'h0000;
  logic [DATA_W-1:0] last_d = 8'h00;
  // Idle buses show the inverse of their last value
  assign pm_word = pm_fetch ? prog[pm_addr[5:0]] : ~last_w;
  assign rf_rdata = rf_rd ? regs[rf_addr] : ~last_d;
  assign ret_addr = stk[sp - 4'h1];
  always @(posedge mclk) begin
    if (pm_fetch) last_w <= prog[pm_addr[5:0]];
    if (rf_rd) last_d <= regs[rf_addr];
    if (rf_wr) regs[rf_addr] <= rf_wdata;
    if (acc_wr) acc <= acc_wdata;
    if (stack_push) begin
      stk[sp] <= push_addr;
      sp <= sp + 4'h1;
    end else if (stack_pop) begin
      sp <= sp - 4'h1;
    end
  end
endmodule // idt_mem_model

// ==== testbench.sv ====
// Self-checking testbench for the instruction decode and timing block
`timescale 1ns/1ps
module testbench;
  import idt_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b1;
  logic [1:0] ptr_in_prog = 2'h0;
  logic [INSTR_W-1:0] pm_word;
  logic [PC_W-1:0] pm_addr, ret_addr, push_addr;
  logic [FA_W-1:0] rf_addr;
  logic [DATA_W-1:0] rf_rdata, rf_wdata, acc_in, acc_wdata;
  logic pm_fetch, rf_rd, rf_wr, acc_wr, ptr_upd, ptr_sel;
  logic stack_push, stack_pop, cycle_start, nop_slot;
  logic [1:0] pointer_update_mode;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int rd_c, upd_c, cs_c, nop_c;
  logic nop_prev;
  int ft [$];
  logic [PC_W-1:0] fa [$];
  logic upd_sel;
  logic [1:0] upd_mode;

  always #5 mclk = ~mclk;

  idt_decode_timing idt_decode_timing_i (.mclk(mclk), .arst_n(arst_n),
    .pm_word(pm_word), .pm_addr(pm_addr), .pm_fetch(pm_fetch),
    .rf_rdata(rf_rdata), .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_wr(rf_wr),
    .rf_wdata(rf_wdata), .acc_in(acc_in), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .ptr_in_prog(ptr_in_prog), .ptr_upd(ptr_upd),
    .ptr_sel(ptr_sel), .pointer_update_mode(pointer_update_mode),
    .ret_addr(ret_addr), .stack_push(stack_push), .stack_pop(stack_pop),
    .push_addr(push_addr), .cycle_start(cycle_start), .nop_slot(nop_slot));

  idt_mem_model idt_mem_model_i (.mclk(mclk), .pm_addr(pm_addr),
    .pm_fetch(pm_fetch), .pm_word(pm_word), .rf_addr(rf_addr),
    .rf_rd(rf_rd), .rf_wr(rf_wr), .rf_wdata(rf_wdata),
    .rf_rdata(rf_rdata), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
    .acc(acc_in), .stack_push(stack_push), .stack_pop(stack_pop),
    .push_addr(push_addr), .ret_addr(ret_addr));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Fetch, read, pointer update and phase monitor
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (pm_fetch) begin
      ft.push_back(cyc);
      fa.push_back(pm_addr);
    end
    if (rf_rd) rd_c = cyc;
    if (ptr_upd) begin
      upd_c = cyc;
      upd_sel = ptr_sel;
      upd_mode = pointer_update_mode;
    end
    if (cycle_start && cs_c > 0) chk(cyc - cs_c, 4);
    if (cycle_start) cs_c = cyc;
    if (nop_slot && !nop_prev) nop_c = cyc;
    nop_prev = nop_slot;
  end

  // Reset, load one instruction at address 0 and run it
  task automatic boot(input logic [13:0] w, input logic [1:0] pip,
    input logic [6:0] f, input logic [7:0] fi, input logic [7:0] ai);
    @(negedge mclk);
    arst_n = 1'b0;
    ptr_in_prog = pip;
    for (int i = 0; i < 64; i++) idt_mem_model_i.prog[i] = 14'h0000;
    for (int i = 0; i < 16; i++) idt_mem_model_i.stk[i] = 15'h0020;
    idt_mem_model_i.prog[0] = w;
    idt_mem_model_i.sp = 4'h0;
    idt_mem_model_i.regs[f] = fi;
    idt_mem_model_i.acc = ai;
    repeat (16) @(negedge mclk);
    ft.delete();
    fa.delete();
    rd_c = 0;
    upd_c = 0;
    cs_c = 0;
    nop_c = 0;
    arst_n = 1'b1;
    repeat (40) @(negedge mclk);
  endtask

  task automatic run_case(input logic [13:0] w, input logic [6:0] f,
    input logic [7:0] fi, input logic [7:0] ai, input logic [7:0] ef,
    input logic [7:0] ea, input int gap, input logic [14:0] nxt);
    boot(w, 2'h0, f, fi, ai);
    chk(idt_mem_model_i.regs[f], ef);
    chk(acc_in, ea);
    chk(ft[1] - ft[0], gap);
    chk(nop_c, (gap == 8) ? ft[0] + 5 : 0);
    if (nxt != 15'h7FFF) chk(fa[1], nxt);
  endtask

  task automatic test_file_ops();
    run_case(14'h07FF, 7'h7F, 8'h21, 8'h14, 8'h35, 8'h14, 4, 15'h1);
    chk(rd_c - ft[0], 3);
    run_case(14'h0202, 7'h02, 8'h50, 8'h10, 8'h50, 8'h40, 4, 15'h1);
    run_case(14'h0090, 7'h10, 8'h33, 8'h5A, 8'h5A, 8'h5A, 4, 15'h1);
    chk(rd_c - ft[0], 3);
    run_case(14'h0EA0, 7'h20, 8'hA5, 8'h00, 8'h5A, 8'h00, 4, 15'h1);
    run_case(14'h1791, 7'h11, 8'h00, 8'h00, 8'h80, 8'h00, 4, 15'h1);
    run_case(14'h1012, 7'h12, 8'hFF, 8'h00, 8'hFE, 8'h00, 4, 15'h1);
    chk(rd_c - ft[0], 3);
    run_case(14'h3077, 7'h12, 8'h00, 8'h00, 8'h00, 8'h77, 4, 15'h1);
  endtask

  task automatic test_two_cycle();
    run_case(14'h2123, 7'h13, 8'h08, 8'h33, 8'h08, 8'h33, 8, 15'h123);
    chk(idt_mem_model_i.stk[0], 15'h001);
    run_case(14'h000A, 7'h13, 8'h08, 8'h33, 8'h08, 8'h33, 8, 15'h033);
    run_case(14'h0008, 7'h13, 8'h08, 8'h33, 8'h08, 8'h33, 8, 15'h020);
    run_case(14'h34A5, 7'h13, 8'h08, 8'h33, 8'h08, 8'hA5, 8, 15'h020);
    run_case(14'h37A5, 7'h13, 8'h08, 8'h33, 8'h08, 8'hA5, 8, 15'h020);
    run_case(14'h0009, 7'h13, 8'h08, 8'h33, 8'h08, 8'h33, 8, 15'h020);
    run_case(14'h2855, 7'h13, 8'h08, 8'h33, 8'h08, 8'h33, 8, 15'h055);
    run_case(14'h3205, 7'h13, 8'h08, 8'h33, 8'h08, 8'h33, 8, 15'h006);
    run_case(14'h000B, 7'h13, 8'h08, 8'h33, 8'h08, 8'h33, 8, 15'h034);
    run_case(14'h1D93, 7'h13, 8'h08, 8'h33, 8'h08, 8'h33, 8, 15'h002);
    run_case(14'h1993, 7'h13, 8'h08, 8'h33, 8'h08, 8'h33, 8, 15'h001);
    run_case(14'h0B93, 7'h13, 8'h01, 8'h33, 8'h00, 8'h33, 8, 15'h002);
    run_case(14'h0F93, 7'h13, 8'h08, 8'h33, 8'h09, 8'h33, 8, 15'h001);
  endtask

  task automatic test_indirect();
    logic [1:0] pip;
    for (int p = 0; p < 2; p++) begin
      for (int n = 0; n < 2; n++) begin
        for (int m = 0; m < 4; m++) begin
          pip = (p == 1) ? 2'h3 : 2'h0;
          boot(14'h0010 | 14'(n * 4 + m), pip, 7'(n), 8'(8'hC0 + n), 8'h00);
          chk(ft[1] - ft[0], (p == 1) ? 8 : 4);
          chk(upd_sel, n);
          chk(upd_mode, m);
          if (p == 0) chk(acc_in, 8'hC0 + n);
          if (p == 0) chk(upd_c - ft[0], (m >= 2) ? 4 : 2);
        end
      end
    end
    boot(14'h0B80, 2'h3, 7'h00, 8'h05, 8'h00);
    chk(ft[1] - ft[0], 12);
    chk(idt_mem_model_i.regs[0], 8'h04);
    boot(14'h0018, 2'h0, 7'h01, 8'h00, 8'h6B);
    chk(idt_mem_model_i.regs[0], 8'h6B);
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    print_verdict();
  end

  initial begin
    test_file_ops();
    test_two_cycle();
    test_indirect();
    print_verdict();
  end
endmodule // testbench
